// *** rtl/scg_palette_end.sv ***
// palette end: free-running video clock and blank-gated shift clock
// Functional notes
// - video clock runs free always; shift clock gated by blank
// - latch blank on video clock falling edge
// - latched blank decides shift clock stop/start
// - shift not slower than video: deterministic gating
// - one extra shift pulse per split flag
// - host raises split flag on strobe rise
// - host drives blank and syncs on fall
// - video period at most sixteen host quanta
// - horizontal total divisible by clock ratio
// - split flag held high thirty ns minimum
`timescale 1ns/100ps
`default_nettype none
module scg_palette_end (
  input  wire logic sys_clk,
  input  wire logic rst,
  scg_link_if.dev   link,
  output var  logic blank_latched,
  output var  logic hsync_latched,
  output var  logic vsync_latched,
  output var  logic shift_running,
  output var  logic extra_pulse,
  output var  logic [7:0] shift_count
);

  // counters and link clock flops
  logic [3:0] vc_cnt_q;
  logic [3:0] vc_cnt_d;
  logic [3:0] sc_cnt_q;
  logic [3:0] sc_cnt_d;
  logic       vid_clk_q;
  logic       sclk_q;

  // synchronisers for the host-driven pins
  logic       blank_s1_q;
  logic       blank_s2_q;
  logic       hs_s1_q;
  logic       hs_s2_q;
  logic       vs_s1_q;
  logic       vs_s2_q;
  logic       flag_s1_q;
  logic       flag_s2_q;
  logic       flag_s3_q;

  // gating state
  logic       blank_lat_q;
  logic       hs_lat_q;
  logic       vs_lat_q;
  logic       run_q;
  logic       run_d;
  logic       pend_q;
  logic       pend_d;
  logic       extra_q;
  logic [7:0] shift_cnt_q;

  // decode of counter positions
  wire        vc_wrap;
  wire        sc_wrap;
  wire        vfall;
  wire        srise;
  wire        flag_rise;
  wire        sclk_d;

  // video clock divider, one period is VID_PER system cycles
  assign vc_wrap  = (vc_cnt_q == scg_pkg::VID_PER - scg_pkg::CNT_ONE);
  assign vc_cnt_d = vc_wrap ? scg_pkg::CNT_ZERO : vc_cnt_q + scg_pkg::CNT_ONE;
  // falling edge of the driven video clock happens when this is true
  assign vfall    = (vc_cnt_d == scg_pkg::VID_HALF);

  // shift clock divider; wrap marks the last low cycle of a period
  assign sc_wrap  = (sc_cnt_q == scg_pkg::SCLK_PER - scg_pkg::CNT_ONE);
  assign sc_cnt_d = sc_wrap ? scg_pkg::CNT_ZERO : sc_cnt_q + scg_pkg::CNT_ONE;

  // split flag edge, read from the second sync stage onward only
  assign flag_rise = flag_s2_q & ~flag_s3_q;

  // decision only at a period boundary, while the pin is low, so a stop
  // never cuts a high phase and a restart always gives a full one
  assign run_d  = sc_wrap ? (blank_lat_q | pend_q) : run_q;
  // a new split request survives a clear of the pending one in the same cycle
  assign pend_d = flag_rise | (pend_q & ~sc_wrap);
  assign sclk_d = (sc_cnt_d < scg_pkg::SCLK_HALF) & run_d;
  assign srise  = sc_wrap & run_d;

  // free-running dividers, never stopped by anything but reset; they park
  // on their last count so the first high phase after reset is full width
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vc_cnt_q  <= scg_pkg::VID_PER - scg_pkg::CNT_ONE;
      sc_cnt_q  <= scg_pkg::SCLK_PER - scg_pkg::CNT_ONE;
      vid_clk_q <= 1'b0;
    end else begin
      vc_cnt_q  <= vc_cnt_d;
      sc_cnt_q  <= sc_cnt_d;
      vid_clk_q <= (vc_cnt_d < scg_pkg::VID_HALF);
    end
  end

  // two-flop synchronisers for the host pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blank_s1_q <= 1'b0;
      blank_s2_q <= 1'b0;
      hs_s1_q    <= 1'b1;
      hs_s2_q    <= 1'b1;
      vs_s1_q    <= 1'b1;
      vs_s2_q    <= 1'b1;
    end else begin
      blank_s1_q <= link.video_blank_n;
      blank_s2_q <= blank_s1_q;
      hs_s1_q    <= link.hsync_n;
      hs_s2_q    <= hs_s1_q;
      vs_s1_q    <= link.vsync_n;
      vs_s2_q    <= vs_s1_q;
    end
  end

  // split flag synchroniser plus one stage for edge finding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flag_s1_q <= 1'b0;
      flag_s2_q <= 1'b0;
      flag_s3_q <= 1'b0;
    end else begin
      flag_s1_q <= link.split_transfer_flag;
      flag_s2_q <= flag_s1_q;
      flag_s3_q <= flag_s2_q;
    end
  end

  // blank and syncs are caught at the video clock falling edge; the host
  // changes them three cycles after that edge, so they have settled before the next one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blank_lat_q <= 1'b0;
      hs_lat_q    <= 1'b1;
      vs_lat_q    <= 1'b1;
    end else if (vfall) begin
      blank_lat_q <= blank_s2_q;
      hs_lat_q    <= hs_s2_q;
      vs_lat_q    <= vs_s2_q;
    end
  end

  // shift clock gate; since SCLK_PER divides VID_PER each blank change
  // lands on the same shift phase every line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_q   <= 1'b0;
      sclk_q  <= 1'b0;
      pend_q  <= 1'b0;
      extra_q <= 1'b0;
    end else begin
      run_q   <= run_d;
      sclk_q  <= sclk_d;
      pend_q  <= pend_d;
      extra_q <= sc_wrap & pend_q & ~blank_lat_q;
    end
  end

  // shift pulses since the last blank onset, for software-free monitoring
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_cnt_q <= scg_pkg::HV_ZERO;
    end else if (vfall & ~blank_s2_q & blank_lat_q) begin
      shift_cnt_q <= scg_pkg::HV_ZERO;
    end else if (srise) begin
      shift_cnt_q <= shift_cnt_q + scg_pkg::HV_ONE;
    end
  end

  // link pins and user-side status, all straight from flops
  assign link.video_clock_out = vid_clk_q;
  assign link.shift_clock_out = sclk_q;
  assign blank_latched        = blank_lat_q;
  assign hsync_latched        = hs_lat_q;
  assign vsync_latched        = vs_lat_q;
  assign shift_running        = run_q;
  assign extra_pulse          = extra_q;
  assign shift_count          = shift_cnt_q;

endmodule : scg_palette_end
`default_nettype wire

// *** common/scg_pkg.sv ***
// constants shared by both ends of the shift and video clock link
package scg_pkg;
  localparam int   CNT_W       = 4;
  // link clock periods in system clock cycles, shift clock at least as fast
  localparam logic [3:0] VID_PER   = 4'h8;
  localparam logic [3:0] VID_HALF  = 4'h4;
  localparam logic [3:0] SCLK_PER  = 4'h4;
  localparam logic [3:0] SCLK_HALF = 4'h2;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  // host clock quantum is the host system clock period
  localparam int   SYS_CLK_NS  = 100;
  localparam logic [4:0] MAX_QUANTA = 5'h10;
  localparam logic [4:0] PER_ONE    = 5'h01;
  localparam logic [4:0] PER_SAT    = 5'h1f;
  // least high time of the split transfer flag
  localparam int   FLAG_HOLD_NS  = 30;
  localparam int   FLAG_CYC_INT  = (FLAG_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [3:0] FLAG_CYC = (FLAG_CYC_INT < 1) ? 4'h1 : 4'(FLAG_CYC_INT);
  // raster in video clocks; total even so it divides by the clock ratio
  localparam int   HV_W        = 8;
  localparam logic [7:0] H_TOTAL   = 8'h10;
  localparam logic [7:0] H_ACTIVE  = 8'h0a;
  localparam logic [7:0] HS_START  = 8'h0c;
  localparam logic [7:0] HS_END    = 8'h0e;
  localparam logic [7:0] V_TOTAL   = 8'h08;
  localparam logic [7:0] V_ACTIVE  = 8'h06;
  localparam logic [7:0] VS_START  = 8'h06;
  localparam logic [7:0] VS_END    = 8'h07;
  localparam logic [7:0] HV_ZERO   = 8'h00;
  localparam logic [7:0] HV_ONE    = 8'h01;
endpackage : scg_pkg

// *** common/scg_link_if.sv ***
// link between palette end and graphics processor end
`timescale 1ns/100ps
`default_nettype none
interface scg_link_if;
  logic video_clock_out;
  logic shift_clock_out;
  logic video_blank_n;
  logic hsync_n;
  logic vsync_n;
  logic split_transfer_flag;

  modport dev (
    output video_clock_out,
    output shift_clock_out,
    input  video_blank_n,
    input  hsync_n,
    input  vsync_n,
    input  split_transfer_flag
  );

  modport gsp (
    input  video_clock_out,
    input  shift_clock_out,
    output video_blank_n,
    output hsync_n,
    output vsync_n,
    output split_transfer_flag
  );
endinterface : scg_link_if
`default_nettype wire

// *** rtl/scg_gsp_end.sv ***
// graphics processor end: raster timing and split transfer flag
`timescale 1ns/100ps
`default_nettype none
module scg_gsp_end (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  scg_link_if.gsp         link,
  input  wire logic       transfer_output_enable,
  output var  logic       video_fall,
  output var  logic       period_fault,
  output var  logic [7:0] h_count,
  output var  logic [7:0] v_count
);

  logic       v_s1_q;
  logic       v_s2_q;
  logic       v_s3_q;
  logic [4:0] per_q;
  logic       fault_q;
  logic       fall_q;
  logic [7:0] h_q;
  logic [7:0] v_q;
  logic [7:0] h_d;
  logic [7:0] v_d;
  logic       blank_n_q;
  logic       hs_n_q;
  logic       vs_n_q;
  logic       toe_q;
  logic [3:0] hold_q;
  logic [3:0] hold_d;
  logic       flag_q;

  wire        vfall;
  wire        h_wrap;
  wire        v_wrap;
  wire        toe_rise;

  // video clock arrives from the palette; edges found after the sync
  assign vfall  = v_s3_q & ~v_s2_q;
  assign h_wrap = (h_q == scg_pkg::H_TOTAL - scg_pkg::HV_ONE);
  assign v_wrap = (v_q == scg_pkg::V_TOTAL - scg_pkg::HV_ONE);
  assign h_d    = h_wrap ? scg_pkg::HV_ZERO : h_q + scg_pkg::HV_ONE;
  assign v_d    = !h_wrap ? v_q : (v_wrap ? scg_pkg::HV_ZERO : v_q + scg_pkg::HV_ONE);

  // flag starts on the strobe rising edge and holds the least high time
  assign toe_rise = transfer_output_enable & ~toe_q;
  assign hold_d   = toe_rise ? scg_pkg::FLAG_CYC :
                    (hold_q != scg_pkg::CNT_ZERO) ? hold_q - scg_pkg::CNT_ONE : hold_q;

  // video clock synchroniser, third stage only for edge finding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      v_s1_q <= 1'b0;
      v_s2_q <= 1'b0;
      v_s3_q <= 1'b0;
    end else begin
      v_s1_q <= link.video_clock_out;
      v_s2_q <= v_s1_q;
      v_s3_q <= v_s2_q;
    end
  end

  // period watch: a slow video clock risks a false refresh shift pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      per_q   <= scg_pkg::PER_ONE;
      fault_q <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      fall_q <= vfall;
      if (vfall) begin
        per_q   <= scg_pkg::PER_ONE;
        fault_q <= fault_q | (per_q > scg_pkg::MAX_QUANTA);
      end else if (per_q != scg_pkg::PER_SAT) begin
        per_q <= per_q + scg_pkg::PER_ONE;
      end
    end
  end

  // raster outputs change only on the video clock falling edge; reset parks
  // on the last position so the first fall opens a full first line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      h_q       <= scg_pkg::H_TOTAL - scg_pkg::HV_ONE;
      v_q       <= scg_pkg::V_TOTAL - scg_pkg::HV_ONE;
      blank_n_q <= 1'b0;
      hs_n_q    <= 1'b1;
      vs_n_q    <= 1'b1;
    end else if (vfall) begin
      h_q       <= h_d;
      v_q       <= v_d;
      blank_n_q <= (h_d < scg_pkg::H_ACTIVE) & (v_d < scg_pkg::V_ACTIVE);
      hs_n_q    <= ~((h_d >= scg_pkg::HS_START) & (h_d < scg_pkg::HS_END));
      vs_n_q    <= ~((v_d >= scg_pkg::VS_START) & (v_d < scg_pkg::VS_END));
    end
  end

  // split transfer flag generator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      toe_q  <= 1'b0;
      hold_q <= scg_pkg::CNT_ZERO;
      flag_q <= 1'b0;
    end else begin
      toe_q  <= transfer_output_enable;
      hold_q <= hold_d;
      flag_q <= (hold_d != scg_pkg::CNT_ZERO);
    end
  end

  assign link.video_blank_n       = blank_n_q;
  assign link.hsync_n             = hs_n_q;
  assign link.vsync_n             = vs_n_q;
  assign link.split_transfer_flag = flag_q;
  assign video_fall               = fall_q;
  assign period_fault             = fault_q;
  assign h_count                  = h_q;
  assign v_count                  = v_q;

endmodule : scg_gsp_end
`default_nettype wire

// *** sim/scg_link_checker.sv ***
// concurrent checks on the link between the palette end and the graphics processor end
`timescale 1ns/100ps
`default_nettype none
module scg_link_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic video_clock_out,
  input wire logic shift_clock_out,
  input wire logic video_blank_n,
  input wire logic hsync_n,
  input wire logic vsync_n,
  input wire logic split_transfer_flag
);
  logic [4:0] lo_q;
  logic [4:0] hi_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // cycles blank held low with no flag, and held high; saturating so a long blank never wraps
  always_ff @(posedge sys_clk) begin
    lo_q <= (rst || video_blank_n || split_transfer_flag) ? 5'h00 : lo_q + {4'h0, lo_q != 5'h1f};
    hi_q <= (rst || !video_blank_n) ? 5'h00 : hi_q + {4'h0, hi_q != 5'h1f};
  end

  vid_high_a: assert property ($rose(video_clock_out) |=> video_clock_out [*3] ##1 !video_clock_out)
    else $error("video clock high time wrong");
  vid_low_a: assert property ($fell(video_clock_out) |=> !video_clock_out [*3] ##1 video_clock_out)
    else $error("video clock low time wrong");
  sclk_pulse_a: assert property ($rose(shift_clock_out) |=> shift_clock_out ##1 !shift_clock_out)
    else $error("shift clock pulse not full width");
  sclk_gap_a: assert property ($fell(shift_clock_out) |=> !shift_clock_out)
    else $error("shift clock low time too short");
  flag_width_a: assert property ($rose(split_transfer_flag) |=> $fell(split_transfer_flag))
    else $error("split flag width wrong");
  split_pulse_a: assert property ($rose(split_transfer_flag) |-> ##[2:7] $rose(shift_clock_out))
    else $error("no shift pulse after split flag");
  blank_stop_a: assert property (lo_q >= 5'h18 |-> !shift_clock_out)
    else $error("shift clock running during blank");
  blank_run_a: assert property (hi_q >= 5'h18 |-> ##[0:3] $rose(shift_clock_out))
    else $error("shift clock stopped during active video");
  blank_edge_a: assert property ($changed(video_blank_n) |-> !video_clock_out)
    else $error("blank changed while video clock high");
  sync_edge_a: assert property ($changed({hsync_n, vsync_n}) |-> !video_clock_out)
    else $error("sync changed while video clock high");
endmodule : scg_link_checker
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench joining the palette end and the graphics processor end
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       sys_clk;
  logic       rst;
  logic       toe;
  logic       blank_latched;
  logic       extra_pulse;
  logic       video_fall;
  logic       period_fault;
  logic       hsync_latched;
  logic       vsync_latched;
  logic       shift_running;
  logic [7:0] shift_count;
  logic [7:0] h_count;
  logic [7:0] v_count;
  int         fails = 0;
  int         tests_run = 0;

  scg_link_if link ();
  scg_palette_end scg_palette_end_i (.sys_clk(sys_clk), .rst(rst), .link(link), .blank_latched(blank_latched),
    .hsync_latched(hsync_latched), .vsync_latched(vsync_latched), .shift_running(shift_running),
    .extra_pulse(extra_pulse), .shift_count(shift_count));
  scg_gsp_end scg_gsp_end_i (.sys_clk(sys_clk), .rst(rst), .link(link), .transfer_output_enable(toe),
    .video_fall(video_fall), .period_fault(period_fault), .h_count(h_count), .v_count(v_count));
  scg_link_checker scg_link_checker_i (.sys_clk(sys_clk), .rst(rst), .video_clock_out(link.video_clock_out),
    .shift_clock_out(link.shift_clock_out), .video_blank_n(link.video_blank_n), .hsync_n(link.hsync_n),
    .vsync_n(link.vsync_n), .split_transfer_flag(link.split_transfer_flag));

  // 10 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // wait for the latched blank to move to val; bounded so a stuck latch cannot hang the run
  task automatic wait_latch(input logic val);
    int n;
    n = 0;
    while (blank_latched !== !val && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    while (blank_latched !== val && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check({7'h00, n < 2000}, 8'h01);
  endtask : wait_latch

  // run cyc cycles, raising the strobe every fourth cycle for pulses times, counting link events
  task automatic watch(input int cyc, input int pulses, output logic [7:0] rises, output logic [7:0] falls,
                       output logic [7:0] extras);
    logic sc_prev;
    logic vc_prev;
    rises = 8'h00;
    falls = 8'h00;
    extras = 8'h00;
    sc_prev = link.shift_clock_out;
    vc_prev = link.video_clock_out;
    for (int i = 0; i < cyc; i++) begin
      toe = (i % 4 == 0) && (i / 4 < pulses);
      @(negedge sys_clk);
      if (link.shift_clock_out && !sc_prev)
        rises = rises + 8'h01;
      if (!link.video_clock_out && vc_prev)
        check({7'h00, blank_latched}, {7'h00, link.video_blank_n});
      falls = falls + {7'h00, video_fall};
      extras = extras + {7'h00, extra_pulse};
      sc_prev = link.shift_clock_out;
      vc_prev = link.video_clock_out;
    end
    toe = 1'b0;
  endtask : watch

  // main sequence, run twice so the second pass starts from a reset in mid-run
  initial begin
    logic [7:0] r;
    logic [7:0] f;
    logic [7:0] e;
    rst = 1'b1;
    toe = 1'b0;
    for (int p = 0; p < 2; p++) begin
      rst = 1'b1;
      repeat (12) @(negedge sys_clk);
      check({6'h00, link.video_clock_out, link.shift_clock_out}, 8'h00);
      rst = 1'b0;
      wait_latch(1'b1);
      watch(128, 0, r, f, e);
      check(r, 8'h14);
      check(f, 8'h10);
      check(e, 8'h00);
      for (int k = 1; k <= 2; k++) begin
        wait_latch(1'b0);
        // land inside the latched sync pulse, well before the blank ends
        repeat (20) @(negedge sys_clk);
        check({7'h00, shift_running}, 8'h00);
        check(shift_count, 8'h00);
        check({6'h00, hsync_latched, vsync_latched}, 8'h01);
        check(h_count, scg_pkg::HS_END - scg_pkg::HV_ONE);
        check(v_count, 8'(k));
        watch(24, k, r, f, e);
        check(r, 8'(k));
        check(e, 8'(k));
        check(shift_count, 8'(k));
      end
    end
    check({7'h00, period_fault}, 8'h00);
    end_sim();
  end

  // watchdog well beyond the under one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
